// >>> cdt_consts.svh
// Purpose: named constants of the opcode decode and state accounting block
// Assumes: included by bare name from package and modules
// Notes: bit positions refer to the first 16-bit instruction word
`ifndef CDT_CONSTS_SVH
`define CDT_CONSTS_SVH

// ----------------------------------------
// Instruction word fields
// ----------------------------------------
`define CDT_WORD_W 16
`define CDT_OPC_MSB 15
`define CDT_OPC_LSB 8
`define CDT_HI_MSB 15
`define CDT_HI_LSB 12
`define CDT_LO_MSB 11
`define CDT_LO_LSB 8
`define CDT_GRP_BIT 7

// ----------------------------------------
// Opcode nibbles
// ----------------------------------------
`define CDT_NIB_0 4'h0
`define CDT_NIB_1 4'h1
`define CDT_NIB_4 4'h4
`define CDT_NIB_5 4'h5
`define CDT_NIB_6 4'h6
`define CDT_NIB_7 4'h7
`define CDT_NIB_9 4'h9
`define CDT_OPC_NOP 8'h00
`define CDT_OPC_ORC 8'h04
`define CDT_OPC_AND_TO_CONDITION_CODE 8'h06
`define CDT_OPC_ADDW 8'h09
`define CDT_OPC_SHIFT_LEFT_LOGICAL 8'h10
`define CDT_OPC_ORR 8'h14
`define CDT_OPC_MULU 8'h50
`define CDT_OPC_RTS 8'h54
`define CDT_OPC_BAND 8'h76
`define CDT_HI_BRANCH 4'h4

// ----------------------------------------
// Cycle counts and state costs
// ----------------------------------------
`define CDT_CNT_W 3
`define CDT_ST_W 8
`define CDT_CNT_0 3'h0
`define CDT_CNT_1 3'h1
`define CDT_CNT_2 3'h2
`define CDT_COST_W 2
`define CDT_COST_MEM 2'h2
`define CDT_COST_PER_FAST 2'h2
`define CDT_COST_PER_SLOW 2'h3
`define CDT_COST_INT 2'h1

`endif

// >>> cdt_pkg.sv
// Purpose: types of the opcode decode and state accounting block
// Assumes: cdt_consts.svh
// Notes: none
`include "cdt_consts.svh"

package cdt_pkg;

   // ----------------------------------------
   // Decoded operations
   // ----------------------------------------
   typedef enum logic [4:0] {
      CDT_OP_UNDEF,
      CDT_OP_NO_OPERATION,
      CDT_OP_SHIFT_LEFT_LOGICAL,
      CDT_OP_BRANCH_ALWAYS,
      CDT_OP_BRANCH_COND,
      CDT_OP_UNSIGNED_MULTIPLY,
      CDT_OP_OR_TO_CONDITION_CODE,
      CDT_OP_AND_TO_CONDITION_CODE,
      CDT_OP_OR_REG,
      CDT_OP_RETURN_FROM_SUBROUTINE,
      CDT_OP_ADD_WORD_REG,
      CDT_OP_BIT_AND_CARRY,
      CDT_OP_ADD_IMM,
      CDT_OP_ADD_WITH_CARRY_IMM,
      CDT_OP_COMPARE_VALUES_IMM,
      CDT_OP_SUBTRACT_WITH_BORROW_IMM,
      CDT_OP_OR_IMM,
      CDT_OP_XOR_IMM,
      CDT_OP_AND_IMM,
      CDT_OP_MOVE_DATA_IMM
   } cdt_op_t;

   // ----------------------------------------
   // Counts of the six cycle types
   // ----------------------------------------
   typedef struct packed {
      logic [`CDT_CNT_W-1:0] fetch;
      logic [`CDT_CNT_W-1:0] br_read;
      logic [`CDT_CNT_W-1:0] stack;
      logic [`CDT_CNT_W-1:0] byte_acc;
      logic [`CDT_CNT_W-1:0] word_acc;
      logic [`CDT_CNT_W-1:0] internal;
   } cdt_cnt_t;

   // ----------------------------------------
   // State cost of each cycle type
   // ----------------------------------------
   typedef struct packed {
      logic [`CDT_COST_W-1:0] fetch;
      logic [`CDT_COST_W-1:0] br_read;
      logic [`CDT_COST_W-1:0] stack;
      logic [`CDT_COST_W-1:0] byte_acc;
      logic [`CDT_COST_W-1:0] word_acc;
      logic [`CDT_COST_W-1:0] internal;
   } cdt_cost_t;

endpackage

// >>> cdt_cost_if.sv
// Purpose: carrier between decoder and state accumulator
// Assumes: cdt_pkg
// Notes: single clock
`timescale 1ns/100ps
`include "cdt_consts.svh"

interface cdt_cost_if;
   import cdt_pkg::*;
   logic valid;
   cdt_cnt_t cnt;
   cdt_cost_t cost;
   logic [`CDT_ST_W-1:0] states;
   logic states_valid;

   modport dec (output valid, output cnt, output cost, input states, input states_valid);
   modport acc (input valid, input cnt, input cost, output states, output states_valid);
endinterface

// >>> cdt_state_acc.sv
// Purpose: weighted sum of cycle counts into execution states
// Assumes: cdt_pkg, cdt_cost_if
// Notes: result registered one edge after the counts
`timescale 1ns/100ps
`include "cdt_consts.svh"

module cdt_state_acc (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Carrier
   cdt_cost_if.acc cif
);
   import cdt_pkg::*;

   // ----------------------------------------
   // Product of one count and one cost
   // ----------------------------------------
   function automatic logic [`CDT_ST_W-1:0] cdt_mul(input logic [`CDT_CNT_W-1:0] n,
                                                  input logic [`CDT_COST_W-1:0] s);
      cdt_mul = `CDT_ST_W'(n) * `CDT_ST_W'(s);
   endfunction

   logic [`CDT_ST_W-1:0] states_r;
   logic [`CDT_ST_W-1:0] states_nxt;
   logic valid_r;

   // Sum over the six cycle types [RL7]
   assign states_nxt = cdt_mul(cif.cnt.fetch, cif.cost.fetch)
                     + cdt_mul(cif.cnt.br_read, cif.cost.br_read)
                     + cdt_mul(cif.cnt.stack, cif.cost.stack)
                     + cdt_mul(cif.cnt.byte_acc, cif.cost.byte_acc)
                     + cdt_mul(cif.cnt.word_acc, cif.cost.word_acc)
                     + cdt_mul(cif.cnt.internal, cif.cost.internal);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         states_r <= '0;
         valid_r <= 1'b0;
      end else begin
         states_r <= cif.valid ? states_nxt : '0;
         valid_r <= cif.valid;
      end
   end

   assign cif.states = states_r;
   assign cif.states_valid = valid_r;
endmodule

// >>> cdt_decoder.sv
// Purpose: opcode decode and execution state count of one instruction
// Assumes: cdt_pkg, cdt_cost_if, cdt_state_acc
// Notes: all outputs settle one edge after instr_valid
//
// Notes on behaviour
// RL1: The operation is taken from bits 15 to 8 of the first instruction word.
// RL2: Split opcodes pick one of two groups by bit 7 of the first instruction word.
// RL3: Low nibble 0 gives no_operation, shift_left_logical, branch_always, unsigned_multiply for high 0, 1, 4, 5.
// RL4: Low nibble 4 gives or_to_condition_code, register OR, branch_carry_clear, return for high 0, 1, 4, 5.
// RL5: High nibbles 8 to F are byte immediate add, add_with_carry, compare, subtract_with_borrow, OR, XOR, AND, move.
// RL6: Stack store and load share the move_data encodings and have none of their own.
// RL7: Execution states are the sum over six cycle types of count times cost.
// RL8: Fetch, branch address read and stack operation on on-chip memory cost 2 states each.
// RL9: A byte access to a peripheral module costs 2 or 3 states depending on the module.
// RL10: Every short branch with 8-bit displacement uses exactly 2 fetches and nothing else.
// RL11: Bit and-carry takes 2 fetches and 1 byte access on a memory operand, 1 fetch on a register.
// RL12: Register word add uses a single fetch and nothing else.
// RL13: AND of an immediate into condition_code_reg uses a single fetch and nothing else.
// RL14: Internal operation costs 1 state and blank opcode cells decode as undefined.
`timescale 1ns/100ps
`include "cdt_consts.svh"

module cdt_decoder (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Instruction in
   input wire logic instr_valid,
   input wire logic [`CDT_WORD_W-1:0] instr_word,
   input wire logic bit_mem_form,
   // Access location
   input wire logic data_in_periph,
   input wire logic periph_slow,
   // Decode out
   output logic dec_valid,
   output cdt_pkg::cdt_op_t dec_op,
   output logic dec_group,
   output logic [3:0] dec_cond,
   output logic dec_undef,
   output cdt_pkg::cdt_cnt_t dec_cnt,
   // States out
   output logic [`CDT_ST_W-1:0] exec_states,
   output logic exec_valid
);
   import cdt_pkg::*;

   // ----------------------------------------
   // Count record from two figures, fetch and byte access
   // ----------------------------------------
   function automatic cdt_cnt_t cdt_mk(input logic [`CDT_CNT_W-1:0] i,
                                       input logic [`CDT_CNT_W-1:0] l);
      cdt_mk = '0;
      cdt_mk.fetch = i;
      cdt_mk.byte_acc = l;
   endfunction

   // ----------------------------------------
   // Defined cell test
   // ----------------------------------------
   function automatic logic cdt_defined(input cdt_op_t op);
      cdt_defined = (op != CDT_OP_UNDEF);
   endfunction

   // ----------------------------------------
   // Field extraction
   // ----------------------------------------
   logic [7:0] opc;
   logic [3:0] hi;
   logic [3:0] lo;
   logic grp;

   assign opc = instr_word[`CDT_OPC_MSB:`CDT_OPC_LSB]; // [RL1]
   assign hi = instr_word[`CDT_HI_MSB:`CDT_HI_LSB];
   assign lo = instr_word[`CDT_LO_MSB:`CDT_LO_LSB];
   assign grp = instr_word[`CDT_GRP_BIT]; // [RL2]

   // ----------------------------------------
   // Cell matches
   // ----------------------------------------
   wire is_nop = (opc == `CDT_OPC_NOP);
   wire is_shift_left_logical = (opc == `CDT_OPC_SHIFT_LEFT_LOGICAL);
   wire is_mulu = (opc == `CDT_OPC_MULU);
   wire is_orc = (opc == `CDT_OPC_ORC);
   wire is_and_to_condition_code = (opc == `CDT_OPC_AND_TO_CONDITION_CODE);
   wire is_orr = (opc == `CDT_OPC_ORR);
   wire is_rts = (opc == `CDT_OPC_RTS);
   wire is_addw = (opc == `CDT_OPC_ADDW);
   wire is_band = (opc == `CDT_OPC_BAND);
   wire is_branch = (hi == `CDT_HI_BRANCH);
   wire is_bra = is_branch && (lo == `CDT_NIB_0);
   wire is_imm = hi[3];

   // ----------------------------------------
   // Operation select
   // ----------------------------------------
   cdt_op_t op_sel;
   cdt_op_t imm_op;
   cdt_op_t bit_op;

   // Byte immediate row, high nibble 8 to F [RL5]
   always_comb begin
      case (hi[2:0])
         3'h0: imm_op = CDT_OP_ADD_IMM;
         3'h1: imm_op = CDT_OP_ADD_WITH_CARRY_IMM;
         3'h2: imm_op = CDT_OP_COMPARE_VALUES_IMM;
         3'h3: imm_op = CDT_OP_SUBTRACT_WITH_BORROW_IMM;
         3'h4: imm_op = CDT_OP_OR_IMM;
         3'h5: imm_op = CDT_OP_XOR_IMM;
         3'h6: imm_op = CDT_OP_AND_IMM;
         3'h7: imm_op = CDT_OP_MOVE_DATA_IMM; // [RL6]
         default: imm_op = CDT_OP_UNDEF;
      endcase
   end

   // Split cell, bit 7 clear selects bit and-carry, set decodes as undefined
   assign bit_op = grp ? CDT_OP_UNDEF : CDT_OP_BIT_AND_CARRY; // [RL2]

   always_comb begin
      op_sel = CDT_OP_UNDEF; // [RL14]
      if (is_imm) begin
         op_sel = imm_op;
      end else if (is_nop) begin
         op_sel = CDT_OP_NO_OPERATION; // [RL3]
      end else if (is_shift_left_logical) begin
         op_sel = CDT_OP_SHIFT_LEFT_LOGICAL; // [RL3]
      end else if (is_bra) begin
         op_sel = CDT_OP_BRANCH_ALWAYS; // [RL3]
      end else if (is_branch) begin
         op_sel = CDT_OP_BRANCH_COND; // [RL4]
      end else if (is_mulu) begin
         op_sel = CDT_OP_UNSIGNED_MULTIPLY; // [RL3]
      end else if (is_orc) begin
         op_sel = CDT_OP_OR_TO_CONDITION_CODE; // [RL4]
      end else if (is_orr) begin
         op_sel = CDT_OP_OR_REG; // [RL4]
      end else if (is_rts) begin
         op_sel = CDT_OP_RETURN_FROM_SUBROUTINE; // [RL4]
      end else if (is_and_to_condition_code) begin
         op_sel = CDT_OP_AND_TO_CONDITION_CODE;
      end else if (is_addw) begin
         op_sel = CDT_OP_ADD_WORD_REG;
      end else if (is_band) begin
         op_sel = bit_op;
      end
   end

   // ----------------------------------------
   // Cycle counts per operation
   // ----------------------------------------
   cdt_cnt_t cnt_sel;

   always_comb begin
      case (op_sel)
         CDT_OP_BRANCH_ALWAYS,
         CDT_OP_BRANCH_COND: begin
            cnt_sel = cdt_mk(`CDT_CNT_2, `CDT_CNT_0); // [RL10]
         end
         CDT_OP_BIT_AND_CARRY: begin
            cnt_sel = bit_mem_form ? cdt_mk(`CDT_CNT_2, `CDT_CNT_1)
                                   : cdt_mk(`CDT_CNT_1, `CDT_CNT_0); // [RL11]
         end
         CDT_OP_ADD_WORD_REG: begin
            cnt_sel = cdt_mk(`CDT_CNT_1, `CDT_CNT_0); // [RL12]
         end
         CDT_OP_AND_TO_CONDITION_CODE: begin
            cnt_sel = cdt_mk(`CDT_CNT_1, `CDT_CNT_0); // [RL13]
         end
         CDT_OP_NO_OPERATION,
         CDT_OP_SHIFT_LEFT_LOGICAL,
         CDT_OP_OR_TO_CONDITION_CODE,
         CDT_OP_OR_REG,
         CDT_OP_ADD_IMM,
         CDT_OP_ADD_WITH_CARRY_IMM,
         CDT_OP_COMPARE_VALUES_IMM,
         CDT_OP_SUBTRACT_WITH_BORROW_IMM,
         CDT_OP_OR_IMM,
         CDT_OP_XOR_IMM,
         CDT_OP_AND_IMM,
         CDT_OP_MOVE_DATA_IMM: begin
            cnt_sel = cdt_mk(`CDT_CNT_1, `CDT_CNT_0);
         end
         CDT_OP_UNDEF: begin
            cnt_sel = '0; // [RL14]
         end
         default: begin
            cnt_sel = '0;
         end
      endcase
   end

   // ----------------------------------------
   // State costs by access location
   // ----------------------------------------
   cdt_cost_t cost_sel;
   logic [`CDT_COST_W-1:0] byte_cost;

   // Peripheral byte access 2 or 3 by module [RL9]
   assign byte_cost = !data_in_periph ? `CDT_COST_MEM
                    : (periph_slow ? `CDT_COST_PER_SLOW : `CDT_COST_PER_FAST);

   assign cost_sel.fetch = `CDT_COST_MEM; // [RL8]
   assign cost_sel.br_read = `CDT_COST_MEM; // [RL8]
   assign cost_sel.stack = `CDT_COST_MEM; // [RL8]
   assign cost_sel.byte_acc = byte_cost;
   assign cost_sel.word_acc = `CDT_COST_MEM;
   assign cost_sel.internal = `CDT_COST_INT; // [RL14]

   // ----------------------------------------
   // State accumulator
   // ----------------------------------------
   cdt_cost_if cif ();

   assign cif.valid = instr_valid && cdt_defined(op_sel); // [RL14]
   assign cif.cnt = cnt_sel;
   assign cif.cost = cost_sel;

   cdt_state_acc u_acc (
      .clk(clk),
      .arst_n(arst_n),
      .cif(cif.acc)
   ); // [RL7]

   // ----------------------------------------
   // Output registers
   // ----------------------------------------
   logic valid_r;
   cdt_op_t op_r;
   logic group_r;
   logic [3:0] cond_r;
   logic undef_r;
   cdt_cnt_t cnt_r;
   cdt_op_t op_nxt;
   logic group_nxt;
   logic [3:0] cond_nxt;
   logic undef_nxt;
   cdt_cnt_t cnt_nxt;

   // Idle cycles clear every field
   assign op_nxt = instr_valid ? op_sel : CDT_OP_UNDEF;
   assign group_nxt = instr_valid && grp; // [RL2]
   assign cond_nxt = instr_valid ? lo : 4'h0;
   assign undef_nxt = instr_valid && !cdt_defined(op_sel); // [RL14]
   assign cnt_nxt = instr_valid ? cnt_sel : '0;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         valid_r <= 1'b0;
      end else begin
         valid_r <= instr_valid;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         op_r <= CDT_OP_UNDEF;
      end else begin
         op_r <= op_nxt;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         group_r <= 1'b0;
      end else begin
         group_r <= group_nxt;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cond_r <= 4'h0;
      end else begin
         cond_r <= cond_nxt;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         undef_r <= 1'b0;
      end else begin
         undef_r <= undef_nxt;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign dec_valid = valid_r;
   assign dec_op = op_r;
   assign dec_group = group_r;
   assign dec_cond = cond_r;
   assign dec_undef = undef_r;
   assign dec_cnt = cnt_r;
   assign exec_states = cif.states;
   assign exec_valid = cif.states_valid;
endmodule

// >>> cdt_decoder_properties.sv
// Purpose: concurrent checks on the decoder top ports
// Assumes: cdt_pkg, cdt_consts.svh
// Notes: bound to every cdt_decoder instance
`timescale 1ns/100ps

module cdt_decoder_properties
   import cdt_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Instruction in
   input wire logic instr_valid,
   input wire logic [15:0] instr_word,
   input wire logic bit_mem_form,
   input wire logic data_in_periph,
   input wire logic periph_slow,
   // Decode out
   input wire logic dec_valid,
   input cdt_pkg::cdt_op_t dec_op,
   input wire logic dec_group,
   input wire logic [3:0] dec_cond,
   input wire logic dec_undef,
   input cdt_pkg::cdt_cnt_t dec_cnt,
   input wire logic [7:0] exec_states,
   input wire logic exec_valid
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   // ----------------------------------------
   // Sequences
   // ----------------------------------------
   sequence s_take(logic [7:0] opc);
      instr_valid && instr_word[15:8] == opc;
   endsequence
   sequence s_bit_mem;
      s_take(8'h76) ##0 !instr_word[7] && bit_mem_form;
   endsequence

   // ----------------------------------------
   // Properties
   // ----------------------------------------
   valid_follows_a: assert property (instr_valid |=> dec_valid)
      else $error("dec_valid missing");
   idle_quiet_a: assert property (!instr_valid |=> !dec_valid && !exec_valid && exec_states == 8'h00)
      else $error("outputs not idle");
   group_bit_a: assert property (instr_valid |=> dec_group == $past(instr_word[7]))
      else $error("group bit wrong");
   branch_always_a: assert property (s_take(8'h40) |=> dec_op == CDT_OP_BRANCH_ALWAYS && exec_states == 8'h04)
      else $error("branch always wrong");
   branch_cond_a: assert property (instr_valid && instr_word[15:12] == 4'h4 && instr_word[11:8] != 4'h0
      |=> dec_cnt == {3'h2, 15'h0000} && dec_cond == $past(instr_word[11:8]))
      else $error("branch counts wrong");
   imm_cost_a: assert property (instr_valid && instr_word[15] |=> dec_cnt == {3'h1, 15'h0000} && exec_states == 8'h02)
      else $error("immediate cost wrong");
   bit_mem_a: assert property (s_bit_mem |=> exec_states == (($past(data_in_periph) && $past(periph_slow)) ? 8'h07 : 8'h06))
      else $error("bit memory form cost wrong");
   undef_quiet_a: assert property (dec_undef |-> !exec_valid && exec_states == 8'h00 && dec_op == CDT_OP_UNDEF)
      else $error("undefined cell has effect");
   add_word_a: assert property (s_take(8'h09) |=> exec_states == 8'h02 && dec_cnt == {3'h1, 15'h0000})
      else $error("word add cost wrong");
   and_cc_a: assert property (s_take(8'h06) |=> dec_op == CDT_OP_AND_TO_CONDITION_CODE && exec_states == 8'h02)
      else $error("and to condition code wrong");
endmodule

bind cdt_decoder cdt_decoder_properties u_props (.clk(clk), .arst_n(arst_n), .instr_valid(instr_valid),
   .instr_word(instr_word), .bit_mem_form(bit_mem_form), .data_in_periph(data_in_periph),
   .periph_slow(periph_slow), .dec_valid(dec_valid), .dec_op(dec_op), .dec_group(dec_group),
   .dec_cond(dec_cond), .dec_undef(dec_undef), .dec_cnt(dec_cnt), .exec_states(exec_states),
   .exec_valid(exec_valid));

// >>> cdt_loc_model.sv
// Purpose: access location of the byte data access
// Assumes: none
// Notes: loc 0 memory, 1 fast peripheral, 2 slow peripheral
`timescale 1ns/100ps

module cdt_loc_model (
   // Location select
   input wire logic [1:0] loc,
   // Location out
   output logic data_in_periph,
   output logic periph_slow
);
   assign data_in_periph = (loc != 2'h0);
   assign periph_slow = (loc == 2'h2);
endmodule

// >>> tb_cpu_opcode_decode_timing.sv
// Purpose: self-checking bench of the opcode decoder
// Assumes: cdt_pkg, cdt_decoder, cdt_loc_model
// Notes: inputs change at the falling edge
`timescale 1ns/100ps

module tb_cpu_opcode_decode_timing;
   import cdt_pkg::*;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic instr_valid = 1'b0;
   logic [15:0] instr_word = 16'h0000;
   logic bit_mem_form = 1'b0;
   logic [1:0] loc = 2'h0;
   logic data_in_periph, periph_slow, dec_valid, dec_group, dec_undef, exec_valid;
   cdt_op_t dec_op;
   logic [3:0] dec_cond;
   cdt_cnt_t dec_cnt;
   logic [7:0] exec_states;
   int bad_count = 0;
   int samples_checked = 0;

   always #2.5 clk = ~clk;

   cdt_loc_model u_loc (.loc(loc), .data_in_periph(data_in_periph), .periph_slow(periph_slow));
   cdt_decoder dut (.clk(clk), .arst_n(arst_n), .instr_valid(instr_valid), .instr_word(instr_word),
      .bit_mem_form(bit_mem_form), .data_in_periph(data_in_periph), .periph_slow(periph_slow),
      .dec_valid(dec_valid), .dec_op(dec_op), .dec_group(dec_group), .dec_cond(dec_cond),
      .dec_undef(dec_undef), .dec_cnt(dec_cnt), .exec_states(exec_states), .exec_valid(exec_valid));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic put(input logic v, input logic [15:0] w, input logic m, input logic [1:0] l);
      @(negedge clk);
      instr_valid = v;
      instr_word = w;
      bit_mem_form = m;
      loc = l;
   endtask

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_op(input cdt_op_t exp);
      samples_checked++;
      if (dec_op !== exp) begin
         bad_count++;
         $display("[FAIL] %0t op got %0d exp %0d", $time, dec_op, exp);
      end
   endtask

   task automatic conclude();
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic sc_reset();
      chk_op(CDT_OP_UNDEF);
      chk_val({dec_valid, exec_valid, dec_undef, exec_states}, 18'h00000, "reset outputs");
   endtask

   task automatic sc_cells();
      logic [15:0] w[7] = '{16'h00A5, 16'h10FF, 16'h40FF, 16'h5033, 16'h0480, 16'h1401, 16'h5477};
      cdt_op_t o[7] = '{CDT_OP_NO_OPERATION, CDT_OP_SHIFT_LEFT_LOGICAL, CDT_OP_BRANCH_ALWAYS,
         CDT_OP_UNSIGNED_MULTIPLY, CDT_OP_OR_TO_CONDITION_CODE, CDT_OP_OR_REG, CDT_OP_RETURN_FROM_SUBROUTINE};
      for (int i = 0; i < 7; i++) begin
         put(1'b1, w[i], 1'b0, 2'h0);
         put(1'b0, 16'h0000, 1'b0, 2'h0);
         chk_op(o[i]);
         chk_val(dec_group, w[i][7], "group");
      end
   endtask

   task automatic sc_imm();
      for (int k = 0; k < 9; k++) begin
         if (k < 8)
            put(1'b1, {k[3:0] + 4'h8, 12'h0A5}, 1'b0, 2'h0);
         else
            put(1'b0, 16'h0000, 1'b0, 2'h0);
         if (k > 0) begin
            chk_op(cdt_op_t'(int'(CDT_OP_ADD_IMM) + k - 1));
            chk_val(dec_cnt, {3'h1, 15'h0000}, "imm counts");
            chk_val(exec_states, 18'h00002, "imm states");
         end
      end
   endtask

   task automatic sc_branch();
      for (int c = 0; c < 16; c++) begin
         put(1'b1, {4'h4, c[3:0], 8'h12}, 1'b0, 2'h0);
         put(1'b0, 16'h0000, 1'b0, 2'h0);
         chk_op(c == 0 ? CDT_OP_BRANCH_ALWAYS : CDT_OP_BRANCH_COND);
         chk_val({dec_cond, dec_cnt}, {c[3:0], 3'h2, 15'h0000}, "branch counts");
         chk_val({exec_valid, exec_states}, 18'h00104, "branch states");
      end
   endtask

   task automatic sc_costs();
      put(1'b1, 16'h0912, 1'b0, 2'h0);
      put(1'b1, 16'h0655, 1'b0, 2'h0);
      chk_val({dec_cnt, exec_states}, {3'h1, 15'h0000, 8'h02}, "word add");
      put(1'b1, 16'h7634, 1'b0, 2'h0);
      chk_op(CDT_OP_AND_TO_CONDITION_CODE);
      chk_val(exec_states, 18'h00002, "and cc states");
      for (int l = 0; l < 3; l++) begin
         put(1'b1, 16'h7634, 1'b1, l[1:0]);
         if (l == 0)
            chk_val(exec_states, 18'h00002, "bit reg form");
         put(1'b0, 16'h0000, 1'b0, 2'h0);
         chk_op(CDT_OP_BIT_AND_CARRY);
         chk_val(dec_cnt, {3'h2, 6'h00, 3'h1, 6'h00}, "bit mem counts");
         chk_val(exec_states, (l == 2) ? 18'h00007 : 18'h00006, "bit mem states");
      end
   endtask

   task automatic sc_undef();
      put(1'b1, 16'h7680, 1'b0, 2'h0);
      put(1'b1, 16'h2000, 1'b0, 2'h0);
      chk_val({dec_undef, exec_valid, dec_group, dec_cnt, exec_states}, 32'h14000000, "undef one");
      put(1'b0, 16'h0000, 1'b0, 2'h0);
      chk_op(CDT_OP_UNDEF);
      chk_val({dec_undef, exec_valid, exec_states}, 18'h00200, "undef two");
      put(1'b0, 16'h0000, 1'b0, 2'h0);
      chk_val({dec_valid, dec_undef}, 18'h00000, "idle");
   endtask

   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      sc_reset();
      @(negedge clk);
      arst_n = 1'b1;
      sc_cells();
      sc_imm();
      sc_branch();
      sc_costs();
      sc_undef();
      conclude();
   end

   initial begin
      #(5 * 2000);
      bad_count++;
      conclude();
   end
endmodule
